/* File: wdr_watchdog.sv */
/*
 * Watchdog reset timer: 8-bit counter on a prescaled derived clock,
 * service key, check bits, gated disable, APB registers, interrupt.
 * Assumes core_clk at 20 MHz and that systemReset feeds the chip reset,
 * which in turn drives the reset input of this block.
 */
`timescale 1ns/1ps
`default_nettype none

module wdr_watchdog
    import wdr_pkg::*;
#(
    parameter int BASE_DIV = WDR_BASE_DIV
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System
    output logic systemReset,
    output logic irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] counter;
        logic [7:0] control;
        logic [7:0] sysctl;
        logic [2:0] status;
        logic [2:0] mask;
        wdr_key_e keyState;
        logic [3:0] pulseCnt;
        logic [31:0] rdata;
    } wdr_state_s;

    wdr_state_s stateReg;
    wdr_state_s stateNext;

    logic access;
    logic wrAccess;
    logic inFrame;
    logic [11:0] offset;
    logic [7:0] wbyte;
    logic tick;
    logic prescClear;
    logic disabled;
    logic overflow;
    logic badKey;
    logic badChk;
    logic goodKey;
    logic fire;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign access = psel && penable;
    assign wrAccess = access && pwrite;
    assign offset = paddr[11:0] - WDR_FRAME_BASE[11:0];
    assign inFrame = (paddr[15:12] == WDR_FRAME_BASE[15:12]);
    // Only the low lane carries data; upper write data dropped
    assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
    assign pready = 1'b1;
    assign pslverr = access && !(inFrame && (offset == WDR_COUNTER_ADDR
        || offset == WDR_KEY_ADDR || offset == WDR_CONTROL_ADDR
        || offset == WDR_SYSCTL_ADDR || offset == WDR_STATUS_ADDR
        || offset == WDR_MASK_ADDR));

    // Gated disable
    assign disabled = stateReg.control[WDR_CTL_DIS_BIT] && stateReg.sysctl[WDR_PERMIT_BIT];

    // Wrap from all ones
    assign overflow = tick && !disabled && (stateReg.counter == 8'hff);
    // Key: arm value then clear value; anything else resets
    assign badKey = wrAccess && inFrame && (offset == WDR_KEY_ADDR) && pstrb[0]
        && !(wbyte == WDR_KEY_ARM
             || (wbyte == WDR_KEY_CLEAR && stateReg.keyState == WDR_KEY_ARMED));
    assign goodKey = wrAccess && inFrame && (offset == WDR_KEY_ADDR) && pstrb[0]
        && wbyte == WDR_KEY_CLEAR && stateReg.keyState == WDR_KEY_ARMED;
    assign badChk = wrAccess && inFrame && (offset == WDR_CONTROL_ADDR) && pstrb[0]
        && (wbyte[WDR_CHK_HI:WDR_CHK_LO] != WDR_CHK_PATTERN);
    assign fire = overflow || badKey || badChk;
    assign prescClear = goodKey || disabled;

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    wdr_prescaler #(
        .BASE_DIV(BASE_DIV)
    ) u_prescaler (
        .core_clk(core_clk),
        .reset(reset),
        .clear(prescClear),
        .prescaleSel(stateReg.control[WDR_PS_HI:0]),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        stateNext = stateReg;
        stateNext.rdata = 32'h0000_0000;
        // Counts with no setup from software
        if (goodKey) begin
            stateNext.counter = 8'h00;
        end else if (tick && !disabled) begin
            stateNext.counter = stateReg.counter + 8'h01;
        end
        if (wrAccess && inFrame && pstrb[0]) begin
            case (offset)
                WDR_KEY_ADDR: begin
                    stateNext.keyState = (wbyte == WDR_KEY_ARM) ? WDR_KEY_ARMED
                                                                : WDR_KEY_IDLE;
                end
                WDR_CONTROL_ADDR: stateNext.control = wbyte;
                WDR_SYSCTL_ADDR: stateNext.sysctl = wbyte;
                WDR_STATUS_ADDR: stateNext.status = stateReg.status & ~wbyte[2:0];
                WDR_MASK_ADDR: stateNext.mask = wbyte[2:0];
                default: stateNext.keyState = stateReg.keyState;
            endcase
        end
        // Set wins over a write-one clear in the same cycle
        if (overflow) stateNext.status[WDR_ST_OVF] = 1'b1;
        if (badKey) stateNext.status[WDR_ST_BADKEY] = 1'b1;
        if (badChk) stateNext.status[WDR_ST_BADCHK] = 1'b1;
        // Stretch the reset so the system sees it cleanly
        if (fire) begin
            stateNext.pulseCnt = 4'(WDR_RESET_PULSE_CYC);
        end else if (stateReg.pulseCnt != 4'h0) begin
            stateNext.pulseCnt = stateReg.pulseCnt - 4'h1;
        end
        // Reads: 8-bit data in low byte, upper bits zero
        if (psel && !penable && !pwrite && inFrame) begin
            case (offset)
                WDR_COUNTER_ADDR: stateNext.rdata = {24'h000000, stateReg.counter};
                WDR_CONTROL_ADDR: stateNext.rdata = {24'h000000, stateReg.control};
                WDR_SYSCTL_ADDR: stateNext.rdata = {24'h000000, stateReg.sysctl};
                WDR_STATUS_ADDR: stateNext.rdata = {29'h0, stateReg.status};
                WDR_MASK_ADDR: stateNext.rdata = {29'h0, stateReg.mask};
                default: stateNext.rdata = 32'h0000_0000;
            endcase
        end else if (access) begin
            stateNext.rdata = stateReg.rdata;
        end
    end

    // Reset value picks fastest rate, divider 512 then 1
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stateReg <= '0;
            stateReg.control <= WDR_CONTROL_RESET;
            stateReg.sysctl <= WDR_SYSCTL_RESET;
            stateReg.keyState <= WDR_KEY_IDLE;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign prdata = stateReg.rdata;
    assign systemReset = (stateReg.pulseCnt != 4'h0);
    assign irq = |(stateReg.status & stateReg.mask);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    overflow_resets_a: assert property (@(posedge core_clk) disable iff (reset)
        overflow |=> systemReset [*2])
        else $error("overflow did not raise system reset");
    counter_runs_a: assert property (@(posedge core_clk) disable iff (reset)
        (tick && !disabled && !goodKey) |=> stateReg.counter == $past(stateReg.counter) + 8'h01)
        else $error("counter did not advance on tick");
    fast_rate_a: assert property (@(posedge core_clk) disable iff (reset)
        (tick && stateReg.control[2:1] == 2'b00) |-> ##1 !tick [*7])
        else $error("fastest rate ticks too often");
    good_key_a: assert property (@(posedge core_clk) disable iff (reset)
        goodKey |=> stateReg.counter == 8'h00 && !systemReset)
        else $error("good key did not clear counter");
    bad_key_a: assert property (@(posedge core_clk) disable iff (reset)
        badKey |=> systemReset && stateReg.status[WDR_ST_BADKEY])
        else $error("bad key did not reset");
    check_bits_a: assert property (@(posedge core_clk) disable iff (reset)
        badChk |=> systemReset && stateReg.status[WDR_ST_BADCHK])
        else $error("bad check bits did not reset");
    gated_disable_a: assert property (@(posedge core_clk) disable iff (reset)
        !stateReg.sysctl[WDR_PERMIT_BIT] && tick |=> stateReg.counter != $past(stateReg.counter))
        else $error("watchdog stopped without permit");
    upper_zero_a: assert property (@(posedge core_clk) disable iff (reset)
        access && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    wrap_zero_a: assert property (@(posedge core_clk) disable iff (reset)
        overflow && !goodKey |=> stateReg.counter == 8'h00)
        else $error("counter did not wrap to zero");

    cov_overflow_c: cover property (@(posedge core_clk) disable iff (reset) overflow);
    cov_service_c: cover property (@(posedge core_clk) disable iff (reset) goodKey);
    cov_badchk_c: cover property (@(posedge core_clk) disable iff (reset) badChk);
    cov_disable_c: cover property (@(posedge core_clk) disable iff (reset) disabled);

endmodule

`default_nettype wire

/* File: wdr_pkg.sv */
/*
 * Package for the watchdog reset timer: register map, field positions,
 * reset values and timing constants.
 * Assumes a single 20 MHz core clock and a 32-bit APB register bus.
 */
`default_nettype none

package wdr_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses within the control frame)
    // ----------------------------------------------------------------
    localparam logic [15:0] WDR_FRAME_BASE = 16'h7020;
    localparam logic [11:0] WDR_COUNTER_ADDR = 12'h000;
    localparam logic [11:0] WDR_KEY_ADDR = 12'h004;
    localparam logic [11:0] WDR_CONTROL_ADDR = 12'h008;
    localparam logic [11:0] WDR_SYSCTL_ADDR = 12'h00c;
    localparam logic [11:0] WDR_STATUS_ADDR = 12'h010;
    localparam logic [11:0] WDR_MASK_ADDR = 12'h014;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int WDR_CTL_DIS_BIT = 6;
    localparam int WDR_CHK_HI = 5;
    localparam int WDR_CHK_LO = 3;
    localparam logic [2:0] WDR_CHK_PATTERN = 3'h5;
    localparam int WDR_PS_HI = 2;
    localparam int WDR_PERMIT_BIT = 5;
    localparam logic [7:0] WDR_KEY_ARM = 8'h55;
    localparam logic [7:0] WDR_KEY_CLEAR = 8'haa;

    // Status bits
    localparam int WDR_ST_OVF = 0;
    localparam int WDR_ST_BADKEY = 1;
    localparam int WDR_ST_BADCHK = 2;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam logic [7:0] WDR_CONTROL_RESET = 8'h00;
    localparam logic [7:0] WDR_SYSCTL_RESET = 8'h00;
    localparam int WDR_BASE_DIV = 512;
    localparam int WDR_RESET_PULSE_NS = 400;
    localparam int WDR_CLK_PERIOD_NS = 50;
    localparam int WDR_RESET_PULSE_CYC =
        (WDR_RESET_PULSE_NS + WDR_CLK_PERIOD_NS - 1) / WDR_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        WDR_KEY_IDLE = 2'b00,
        WDR_KEY_ARMED = 2'b01
    } wdr_key_e;

endpackage

`default_nettype wire

/* File: wdr_prescaler.sv */
/*
 * Prescaler: divides the core clock into the derived watchdog tick and
 * then by 1..64 as the prescale select bits choose.
 * Assumes a synchronous clear from the parent on service or gated disable.
 */
`timescale 1ns/1ps
`default_nettype none

module wdr_prescaler
    import wdr_pkg::*;
#(
    parameter int BASE_DIV = WDR_BASE_DIV
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic clear,
    input wire logic [2:0] prescaleSel,
    // Output
    output logic tick
);

    typedef struct packed {
        logic [8:0] base;
        logic [5:0] post;
    } wdr_ps_s;

    wdr_ps_s stateReg;
    wdr_ps_s stateNext;
    logic baseTick;
    logic [5:0] postMask;

    // Divider selection; 00x both divide by one
    always_comb begin
        case (prescaleSel)
            3'h0, 3'h1: postMask = 6'h00;
            3'h2: postMask = 6'h01;
            3'h3: postMask = 6'h03;
            3'h4: postMask = 6'h07;
            3'h5: postMask = 6'h0f;
            3'h6: postMask = 6'h1f;
            default: postMask = 6'h3f;
        endcase
    end

    assign baseTick = (stateReg.base == 9'(BASE_DIV - 1));

    always_comb begin
        stateNext = stateReg;
        if (clear) begin
            stateNext.base = 9'h000;
            stateNext.post = 6'h00;
        end else begin
            stateNext.base = baseTick ? 9'h000 : stateReg.base + 9'h001;
            if (baseTick) begin
                stateNext.post = ((stateReg.post & postMask) == postMask) ? 6'h00
                                 : stateReg.post + 6'h01;
            end
        end
    end

    assign tick = baseTick && ((stateReg.post & postMask) == postMask) && !clear;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stateReg <= '0;
        end else begin
            stateReg <= stateNext;
        end
    end

endmodule

`default_nettype wire

/* File: wdr_testbench.sv */
/*
 * Self-checking testbench for the watchdog reset timer, driven over APB.
 * Assumes wdr_pkg and wdr_watchdog are compiled first; systemReset is
 * observed only, the bench drives reset itself.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench
    import wdr_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int BASE = 8;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h1;
    logic [31:0] prdata;
    logic pready, pslverr, systemReset, irq, lastErr;
    logic [31:0] d, c0, c1;
    int failCount = 0;
    int testsRun = 0;
    int cyc = 0;
    int relCyc, n, divv, expN, diff;

    wdr_watchdog #(.BASE_DIV(BASE)) wdr_watchdog_inst (.core_clk(core_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .systemReset(systemReset), .irq(irq));

    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] off, input logic [31:0] wd,
                       output logic [31:0] rdat);
        int guard;
        guard = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= WDR_FRAME_BASE + {4'h0, off};
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            guard++;
        end while (pready !== 1'b1 && guard < 50);
        if (guard >= 50) chk(32'h0, 32'h1);
        rdat = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] off, input logic [31:0] wd);
        logic [31:0] unused;
        apb(1'b1, off, wd, unused);
    endtask

    task automatic rd(input logic [11:0] off, output logic [31:0] rdat);
        apb(1'b0, off, 32'h0, rdat);
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        relCyc = cyc;
    endtask

    // Trip seen within a bound, then status, mask, irq and W1C
    task automatic expect_trip(input int bitPos, input int limit);
        int k;
        k = 0;
        while (systemReset !== 1'b1 && k < limit) begin
            @(posedge core_clk);
            k++;
        end
        chk(systemReset, 1'b1);
        rd(WDR_STATUS_ADDR, d);
        chk(d, 32'h1 << bitPos);
        chk(irq, 1'b0);
        wr(WDR_MASK_ADDR, 32'h1 << bitPos);
        @(posedge core_clk);
        chk(irq, 1'b1);
        wr(WDR_STATUS_ADDR, 32'h1 << bitPos);
        @(posedge core_clk);
        chk(irq, 1'b0);
        do_reset();
    endtask

    task automatic wrap_up();
        $display("compares=%0d mismatches=%0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        #(100000 * 50);
        failCount++;
        wrap_up();
    end

    initial begin
        do_reset();
        rd(WDR_CONTROL_ADDR, d);
        chk(d, 32'h0);
        rd(WDR_SYSCTL_ADDR, d);
        chk(d, 32'h0);
        // Unserviced: overflow after 256 derived ticks
        n = 0;
        while (systemReset !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        chk((cyc - relCyc >= 256 * BASE - 8) && (cyc - relCyc <= 256 * BASE + 12), 1);
        expect_trip(WDR_ST_OVF, 4);
        // Unmapped offset refused
        rd(12'h038, d);
        chk(d, 32'h0);
        chk({31'h0, lastErr}, 32'h1);
        // Prescale table, upper write bytes ignored
        for (int ps = 0; ps < 8; ps++) begin
            divv = (ps < 2) ? 1 : (1 << (ps - 1));
            wr(WDR_CONTROL_ADDR, 32'hffffff28 | ps);
            rd(WDR_CONTROL_ADDR, d);
            chk(d, 32'h28 | ps);
            wr(WDR_KEY_ADDR, 32'h55);
            wr(WDR_KEY_ADDR, 32'haa);
            rd(WDR_COUNTER_ADDR, c0);
            repeat (1024) @(posedge core_clk);
            rd(WDR_COUNTER_ADDR, c1);
            diff = int'((c1[7:0] - c0[7:0]) & 8'hff);
            expN = 1024 / (BASE * divv);
            chk(diff >= expN - 1 && diff <= expN + 1, 1);
            chk(c0 < 4, 1);
            chk(systemReset, 1'b0);
        end
        // Strobe low: bad control byte not taken
        pstrb <= 4'h0;
        wr(WDR_CONTROL_ADDR, 32'h0);
        pstrb <= 4'h1;
        rd(WDR_CONTROL_ADDR, d);
        chk(d, 32'h2f);
        chk(systemReset, 1'b0);
        do_reset();
        // Disable refused without permit, then honoured
        wr(WDR_CONTROL_ADDR, 32'h68);
        rd(WDR_COUNTER_ADDR, c0);
        repeat (64) @(posedge core_clk);
        rd(WDR_COUNTER_ADDR, c1);
        chk(c1 != c0, 1);
        wr(WDR_SYSCTL_ADDR, 32'h20);
        wr(WDR_CONTROL_ADDR, 32'h68);
        rd(WDR_COUNTER_ADDR, c0);
        repeat (64) @(posedge core_clk);
        rd(WDR_COUNTER_ADDR, c1);
        chk(c1, c0);
        do_reset();
        // Faulty key values and bad check bits
        wr(WDR_KEY_ADDR, 32'h12);
        expect_trip(WDR_ST_BADKEY, 4);
        wr(WDR_KEY_ADDR, 32'haa);
        expect_trip(WDR_ST_BADKEY, 4);
        wr(WDR_CONTROL_ADDR, 32'h30);
        expect_trip(WDR_ST_BADCHK, 4);
        wrap_up();
    end
endmodule

`default_nettype wire
